// *** design/psr_regulator.sv ***
// PID speed regulator with AHB-Lite register slave
//
// Function
// R01: Each analog input maps linearly to percent between its low and high settings.
// R02: Low setting above high setting inverts the scaling.
// R03: Reference code 5 picks voltage input, code 6 picks current input.
// R04: Error within plus or minus deadband around reference is ignored.
// R05: Start or enable loads preload frequency into the integrator.
// R06: Trim mode clamps output between upper and lower trim limits.
// R07: Integration freezes while output sits at a limit.
// R08: Proportional term is gain times error, gain 1 gives full frequency.
// R09: Proportional gain zero disables the proportional term.
// R10: Integral accumulates error over integral time, full error reaches full frequency.
// R11: Integral time zero disables the integral term.
// R12: Differential term is rate times change between previous and current error.
// R13: Rate 1.00 gives 0.1 % max frequency at 1 %/s error change.
// R14: Differential rate zero, the reset default, disables that term.
// R15: Output is the sum of proportional, integral and differential terms.
// R16: Trim select zero drops speed reference, output is whole command.
// R17: Trim select nonzero adds output to the ramped speed reference.
// R18: Negative voltage input counts as zero.
// R19: Error is reference percent minus feedback percent, once per sample.
//
// Register access over AHB-Lite and the register addresses were decided locally.
`timescale 1ns/10ps
module psr_regulator #(
  parameter int unsigned SAMPLE_CYCLES = psr_pkg::SAMPLE_CYCLES
) (
  // Clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // AHB-Lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  // Analog inputs in 0.1 % of range
  input  wire logic signed [11:0] volt_in,
  input  wire logic [11:0]        current_in,
  // Drive command path
  input  wire logic               run,
  input  wire logic signed [15:0] ramped_speed_ref,
  output logic signed [15:0]      pid_output,
  output logic signed [15:0]      freq_command
);
  localparam int SAMPLE_US = (SAMPLE_CYCLES / psr_pkg::CLK_MHZ) > 0 ? (SAMPLE_CYCLES / psr_pkg::CLK_MHZ) : 1;

  // Register file and bus state
  logic [31:0] ctrl, volt_scale, cur_scale, max_freq, setpoint;
  logic [31:0] loop_reg      [0:1][0:psr_pkg::LOOP_WORDS-1];
  logic [31:0] next_loop_reg [0:1][0:psr_pkg::LOOP_WORDS-1];
  logic [31:0] next_ctrl, next_volt_scale, next_cur_scale, next_max_freq, next_setpoint;
  logic        wr_q, next_wr_q;
  logic [7:0]  waddr_q, next_waddr_q;
  logic [31:0] next_hrdata;
  logic        accept;

  // Synchronisers and sample state
  logic signed [11:0] volt_s1, volt_s2, volt_s3, volt_ok, next_volt_ok;
  logic [11:0]        cur_s1, cur_s2, cur_s3, cur_ok, next_cur_ok;
  psr_pkg::psr_state_type state, next_state;
  logic [31:0]        tick_cnt, next_tick_cnt;
  logic               active_q, next_active_q, active;
  logic signed [47:0] integ, next_integ;
  logic signed [11:0] err_reg, next_err_reg, err_prev, next_err_prev;
  logic               sat, next_sat;
  logic signed [15:0] next_pid_output, next_freq_command;
  logic               sc_start, next_sc_start, in_start, next_in_start;

  psr_div_if #(.W(32)) div_volt ();
  psr_div_if #(.W(32)) div_cur ();
  psr_div_if #(.W(64)) div_int ();

  // Active loop settings
  logic        lsel;
  logic [3:0]  ref_src, fb_src, trim_sel;
  logic [15:0] deadband, preload, trim_hi, pgain, itime, drate, mfreq;
  logic signed [15:0] trim_lo;

  assign lsel     = ctrl[psr_pkg::CTRL_LOOPSEL];
  assign ref_src  = loop_reg[lsel][psr_pkg::W_SRC][psr_pkg::SRC_REF_LSB +: 4];
  assign fb_src   = loop_reg[lsel][psr_pkg::W_SRC][psr_pkg::SRC_FB_LSB +: 4];
  assign trim_sel = loop_reg[lsel][psr_pkg::W_SRC][psr_pkg::SRC_TRIM_LSB +: 4];
  assign deadband = loop_reg[lsel][psr_pkg::W_DEADBAND][15:0];
  assign preload  = loop_reg[lsel][psr_pkg::W_PRELOAD][15:0];
  assign trim_hi  = loop_reg[lsel][psr_pkg::W_TRIM][15:0];
  assign trim_lo  = loop_reg[lsel][psr_pkg::W_TRIM][psr_pkg::TRIM_LO_LSB +: 16];
  assign pgain    = loop_reg[lsel][psr_pkg::W_PGAIN][15:0];
  assign itime    = loop_reg[lsel][psr_pkg::W_ITIME][15:0];
  assign drate    = loop_reg[lsel][psr_pkg::W_DRATE][15:0];
  assign mfreq    = max_freq[15:0];
  assign active   = ctrl[psr_pkg::CTRL_ENABLE] & run;
  assign accept   = hsel & hready & htrans[1];

  // Scalers: (x - lo) * full / (hi - lo); a reversed pair gives a negative divisor
  logic signed [31:0] volt_pos;
  assign volt_pos      = volt_ok[11] ? 32'sh0000_0000 : 32'(volt_ok);                 // [R18]
  assign div_volt.start = sc_start;
  assign div_volt.num  = (volt_pos - 32'(volt_scale[15:0])) * 32'(psr_pkg::PCT_FULL); // [R01]
  assign div_volt.den  = 32'(volt_scale[psr_pkg::SCALE_HI_LSB +: 16]) - 32'(volt_scale[15:0]); // [R02]
  assign div_cur.start = sc_start;
  assign div_cur.num   = (32'(cur_ok) - 32'(cur_scale[15:0])) * 32'(psr_pkg::PCT_FULL);   // [R01]
  assign div_cur.den   = 32'(cur_scale[psr_pkg::SCALE_HI_LSB +: 16]) - 32'(cur_scale[15:0]); // [R02]
  assign div_int.start = in_start;

  psr_divider #(.W(32)) u_div_volt (.hclk(hclk), .hresetn(hresetn), .div(div_volt));
  psr_divider #(.W(32)) u_div_cur  (.hclk(hclk), .hresetn(hresetn), .div(div_cur));
  psr_divider #(.W(64)) u_div_int  (.hclk(hclk), .hresetn(hresetn), .div(div_int));

  // Limit a scaled percent to 0..full
  function automatic logic signed [11:0] pct_clamp(input logic signed [31:0] v);
    if (v < 0)
      return 12'sh000;
    else if (v > 32'(psr_pkg::PCT_FULL))
      return 12'(psr_pkg::PCT_FULL);
    else
      return v[11:0];
  endfunction : pct_clamp

  // Bus decode, register writes and read data
  always_comb
  begin
    next_ctrl       = ctrl;
    next_volt_scale = volt_scale;
    next_cur_scale  = cur_scale;
    next_max_freq   = max_freq;
    next_setpoint   = setpoint;
    next_loop_reg   = loop_reg;
    next_wr_q       = accept & hwrite;
    next_waddr_q    = haddr[7:0];
    next_hrdata     = 32'h0000_0000;
    if (wr_q)
    begin
      case (waddr_q)
        psr_pkg::OFF_CTRL:       next_ctrl       = hwdata & psr_pkg::MASK_CTRL;
        psr_pkg::OFF_VOLT_SCALE: next_volt_scale = hwdata;
        psr_pkg::OFF_CUR_SCALE:  next_cur_scale  = hwdata;
        psr_pkg::OFF_MAX_FREQ:   next_max_freq   = hwdata & psr_pkg::MASK_HALF;
        psr_pkg::OFF_SETPOINT:   next_setpoint   = hwdata & psr_pkg::MASK_HALF;
        default:
        begin
          if (waddr_q[7:6] == psr_pkg::LOOP_REGION && waddr_q[4:2] <= psr_pkg::W_DRATE)
            next_loop_reg[waddr_q[5]][waddr_q[4:2]] = hwdata & (waddr_q[4:2] == psr_pkg::W_SRC ?
              psr_pkg::MASK_SRC : (waddr_q[4:2] == psr_pkg::W_TRIM ? psr_pkg::MASK_FULL : psr_pkg::MASK_HALF));
        end
      endcase
    end
    if (accept && !hwrite)
    begin
      case (haddr[7:0])
        psr_pkg::OFF_CTRL:       next_hrdata = ctrl;
        psr_pkg::OFF_VOLT_SCALE: next_hrdata = volt_scale;
        psr_pkg::OFF_CUR_SCALE:  next_hrdata = cur_scale;
        psr_pkg::OFF_MAX_FREQ:   next_hrdata = max_freq;
        psr_pkg::OFF_SETPOINT:   next_hrdata = setpoint;
        psr_pkg::OFF_PID_OUT:    next_hrdata = 32'(pid_output);
        psr_pkg::OFF_FREQ_CMD:   next_hrdata = 32'(freq_command);
        psr_pkg::OFF_ERROR:      next_hrdata = 32'(err_reg);
        default:
        begin
          if (haddr[7:6] == psr_pkg::LOOP_REGION && haddr[4:2] <= psr_pkg::W_DRATE)
            next_hrdata = loop_reg[haddr[5]][haddr[4:2]];
        end
      endcase
    end
  end

  // Bus and register file registers; zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl       <= psr_pkg::RST_CTRL;
      volt_scale <= psr_pkg::RST_SCALE;
      cur_scale  <= psr_pkg::RST_SCALE;
      max_freq   <= psr_pkg::RST_MAX_FREQ;
      setpoint   <= psr_pkg::RST_SETPOINT;
      for (int l = 0; l < 2; l++)
      begin
        loop_reg[l][psr_pkg::W_SRC]      <= psr_pkg::RST_ZERO;
        loop_reg[l][psr_pkg::W_DEADBAND] <= psr_pkg::RST_ZERO;
        loop_reg[l][psr_pkg::W_PRELOAD]  <= psr_pkg::RST_ZERO;
        loop_reg[l][psr_pkg::W_TRIM]     <= psr_pkg::RST_TRIM;
        loop_reg[l][psr_pkg::W_PGAIN]    <= psr_pkg::RST_PGAIN;
        loop_reg[l][psr_pkg::W_ITIME]    <= psr_pkg::RST_ITIME;
        loop_reg[l][psr_pkg::W_DRATE]    <= psr_pkg::RST_DRATE;     // [R14]
      end
      wr_q      <= 1'b0;
      waddr_q   <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end
    else
    begin
      ctrl       <= next_ctrl;
      volt_scale <= next_volt_scale;
      cur_scale  <= next_cur_scale;
      max_freq   <= next_max_freq;
      setpoint   <= next_setpoint;
      loop_reg   <= next_loop_reg;
      wr_q       <= next_wr_q;
      waddr_q    <= next_waddr_q;
      hrdata     <= next_hrdata;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end
  end

  // Regulator sequencer and arithmetic
  always_comb
  begin
    logic signed [11:0] ref_pct, fb_pct, err, err_eff;
    logic signed [47:0] p_term, d_term, sum, lim_hi, lim_lo, clamped, cmd;
    ref_pct = 12'sh000;
    fb_pct  = 12'sh000;
    err     = 12'sh000;
    err_eff = 12'sh000;
    p_term  = 48'sh0;
    d_term  = 48'sh0;
    sum     = 48'sh0;
    lim_hi  = 48'sh0;
    lim_lo  = 48'sh0;
    clamped = 48'sh0;
    cmd     = 48'sh0;
    next_state        = state;
    next_tick_cnt     = (tick_cnt == SAMPLE_CYCLES - 1) ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
    next_active_q     = active;
    next_integ        = integ;
    next_err_reg      = err_reg;
    next_err_prev     = err_prev;
    next_sat          = sat;
    next_pid_output   = pid_output;
    next_freq_command = freq_command;
    next_sc_start     = 1'b0;
    next_in_start     = 1'b0;
    div_int.num       = 64'(err_reg) * 64'(mfreq) * 64'(SAMPLE_US) * (64'sh1 <<< psr_pkg::INTEG_FRAC); // [R10]
    div_int.den       = 64'(itime) * 64'(psr_pkg::I_DEN_SCALE);                                         // [R11]
    case (state)
      psr_pkg::ST_IDLE:
      begin
        if (active && tick_cnt == SAMPLE_CYCLES - 1)
        begin
          next_sc_start = 1'b1;
          next_state    = psr_pkg::ST_SCALE;
        end
      end
      psr_pkg::ST_SCALE:
      begin
        if (div_volt.done)
        begin
          case (ref_src)
            psr_pkg::REF_VOLT: ref_pct = pct_clamp(div_volt.quo);    // [R03]
            psr_pkg::REF_CUR:  ref_pct = pct_clamp(div_cur.quo);     // [R03]
            default:           ref_pct = 12'(setpoint[15:0]);
          endcase
          fb_pct  = (fb_src == psr_pkg::FB_CUR) ? pct_clamp(div_cur.quo) : pct_clamp(div_volt.quo);
          err     = ref_pct - fb_pct;                                // [R19]
          err_eff = ((err < 0 ? -err : err) <= $signed({1'b0, deadband})) ? 12'sh000 : err; // [R04]
          next_err_prev = err_reg;
          next_err_reg  = err_eff;
          next_in_start = 1'b1;
          next_state    = psr_pkg::ST_INTEG;
        end
      end
      psr_pkg::ST_INTEG:
      begin
        if (div_int.done)
        begin
          if (pgain != 16'h0000)                                     // [R09]
            p_term = $signed(48'(pgain)) * 48'(err_reg) * $signed(48'(mfreq)) / 48'(psr_pkg::P_DIV); // [R08]
          if (drate != 16'h0000)                                     // [R14]
            d_term = $signed(48'(drate)) * 48'(err_reg - err_prev) * $signed(48'(mfreq))
              / 48'(SAMPLE_US); // [R12] [R13]
          sum = p_term + ((itime != 16'h0000) ? (integ >>> psr_pkg::INTEG_FRAC) : 48'sh0) + d_term; // [R15]
          if (trim_sel != 4'h0)
          begin
            lim_hi = 48'(trim_hi);                                   // [R06]
            lim_lo = 48'(trim_lo);                                   // [R06]
          end
          else
          begin
            lim_hi = 48'(mfreq);
            lim_lo = 48'sh0;
          end
          clamped  = (sum >= lim_hi) ? lim_hi : ((sum <= lim_lo) ? lim_lo : sum);
          next_sat = (sum >= lim_hi) || (sum <= lim_lo);
          if (!next_sat && itime != 16'h0000)                        // [R07]
            next_integ = integ + 48'(div_int.quo);                   // [R10]
          cmd = (trim_sel != 4'h0) ? clamped + 48'(ramped_speed_ref) : clamped; // [R16] [R17]
          if (cmd > 48'sh7FFF)
            cmd = 48'sh7FFF;
          else if (cmd < -48'sh8000)
            cmd = -48'sh8000;
          next_pid_output   = clamped[15:0];
          next_freq_command = cmd[15:0];
          next_state        = psr_pkg::ST_IDLE;
        end
      end
      default: next_state = psr_pkg::ST_IDLE;
    endcase
    if (active && !active_q)
    begin
      next_integ        = 48'(preload) <<< psr_pkg::INTEG_FRAC;     // [R05]
      next_freq_command = (trim_sel != 4'h0) ? 16'(32'(ramped_speed_ref) + 32'(preload)) : preload; // [R05]
      next_pid_output   = preload;
      next_err_reg      = 12'sh000;
      next_err_prev     = 12'sh000;
      next_sat          = 1'b0;
    end
    else if (!active)
    begin
      next_state        = psr_pkg::ST_IDLE;
      next_pid_output   = 16'sh0000;
      next_freq_command = ramped_speed_ref;
    end
  end

  // Synchronisers: a new input word counts once stages two and three agree
  always_comb
  begin
    next_volt_ok = (volt_s2 == volt_s3) ? volt_s3 : volt_ok;
    next_cur_ok  = (cur_s2 == cur_s3) ? cur_s3 : cur_ok;
  end

  // Regulator registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      volt_s1      <= 12'sh000;
      volt_s2      <= 12'sh000;
      volt_s3      <= 12'sh000;
      volt_ok      <= 12'sh000;
      cur_s1       <= 12'h000;
      cur_s2       <= 12'h000;
      cur_s3       <= 12'h000;
      cur_ok       <= 12'h000;
      state        <= psr_pkg::ST_IDLE;
      tick_cnt     <= 32'h0000_0000;
      active_q     <= 1'b0;
      integ        <= 48'sh0;
      err_reg      <= 12'sh000;
      err_prev     <= 12'sh000;
      sat          <= 1'b0;
      pid_output   <= 16'sh0000;
      freq_command <= 16'sh0000;
      sc_start     <= 1'b0;
      in_start     <= 1'b0;
    end
    else
    begin
      volt_s1      <= volt_in;
      volt_s2      <= volt_s1;
      volt_s3      <= volt_s2;
      volt_ok      <= next_volt_ok;
      cur_s1       <= current_in;
      cur_s2       <= cur_s1;
      cur_s3       <= cur_s2;
      cur_ok       <= next_cur_ok;
      state        <= next_state;
      tick_cnt     <= next_tick_cnt;
      active_q     <= next_active_q;
      integ        <= next_integ;
      err_reg      <= next_err_reg;
      err_prev     <= next_err_prev;
      sat          <= next_sat;
      pid_output   <= next_pid_output;
      freq_command <= next_freq_command;
      sc_start     <= next_sc_start;
      in_start     <= next_in_start;
    end
  end
endmodule : psr_regulator

// *** design/psr_pkg.sv ***
// Shared constants, register map and types of the PID speed regulator
package psr_pkg;
  // Register byte offsets (global block)
  localparam logic [7:0] OFF_CTRL       = 8'h00;
  localparam logic [7:0] OFF_VOLT_SCALE = 8'h04;
  localparam logic [7:0] OFF_CUR_SCALE  = 8'h08;
  localparam logic [7:0] OFF_MAX_FREQ   = 8'h0C;
  localparam logic [7:0] OFF_SETPOINT   = 8'h10;
  localparam logic [7:0] OFF_PID_OUT    = 8'h14;
  localparam logic [7:0] OFF_FREQ_CMD   = 8'h18;
  localparam logic [7:0] OFF_ERROR      = 8'h1C;
  // Per-loop banks: loop 0 at 0x40, loop 1 at 0x60, word index in bits 4:2
  localparam logic [1:0] LOOP_REGION    = 2'h1;
  localparam int         LOOP_WORDS     = 7;
  localparam logic [2:0] W_SRC          = 3'h0;
  localparam logic [2:0] W_DEADBAND     = 3'h1;
  localparam logic [2:0] W_PRELOAD      = 3'h2;
  localparam logic [2:0] W_TRIM         = 3'h3;
  localparam logic [2:0] W_PGAIN        = 3'h4;
  localparam logic [2:0] W_ITIME        = 3'h5;
  localparam logic [2:0] W_DRATE        = 3'h6;
  // Field positions
  localparam int CTRL_ENABLE  = 0;
  localparam int CTRL_LOOPSEL = 1;
  localparam int SRC_REF_LSB  = 0;
  localparam int SRC_FB_LSB   = 4;
  localparam int SRC_TRIM_LSB = 8;
  localparam int SCALE_HI_LSB = 16;
  localparam int TRIM_LO_LSB  = 16;
  // Write masks (unused bits read as zero)
  localparam logic [31:0] MASK_CTRL  = 32'h0000_0003;
  localparam logic [31:0] MASK_HALF  = 32'h0000_FFFF;
  localparam logic [31:0] MASK_SRC   = 32'h0000_0FFF;
  localparam logic [31:0] MASK_FULL  = 32'hFFFF_FFFF;
  // Source codes
  localparam logic [3:0] REF_VOLT = 4'h5;
  localparam logic [3:0] REF_CUR  = 4'h6;
  localparam logic [3:0] FB_CUR   = 4'h1;
  // Reset values
  localparam logic [31:0] RST_CTRL     = 32'h0000_0000;
  localparam logic [31:0] RST_SCALE    = 32'h03E8_0000;
  localparam logic [31:0] RST_MAX_FREQ = 32'h0000_0258;
  localparam logic [31:0] RST_SETPOINT = 32'h0000_0000;
  localparam logic [31:0] RST_ZERO     = 32'h0000_0000;
  localparam logic [31:0] RST_TRIM     = 32'h0000_0258;
  localparam logic [31:0] RST_PGAIN    = 32'h0000_0064;
  localparam logic [31:0] RST_ITIME    = 32'h0000_0014;
  localparam logic [31:0] RST_DRATE    = 32'h0000_0000;
  // Arithmetic scales: percent in 0.1 %, gain in 0.01, time in 0.1 s, freq in 0.1 Hz
  localparam int PCT_FULL    = 1000;
  localparam int P_DIV       = 100000;
  localparam int I_DEN_SCALE = 100000000;
  localparam int INTEG_FRAC  = 16;
  // Timing
  localparam int CLK_MHZ        = 125;
  localparam int SAMPLE_TIME_US = 1000;
  localparam int SAMPLE_CYCLES  = SAMPLE_TIME_US * CLK_MHZ;
  // Sample sequencer
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SCALE = 2'b01,
    ST_INTEG = 2'b10
  } psr_state_type;
endpackage : psr_pkg

// *** design/psr_div_if.sv ***
// Request and answer bundle between the regulator and a serial divider
`timescale 1ns/10ps
interface psr_div_if #(parameter int W = 32);
  logic                start;
  logic signed [W-1:0] num;
  logic signed [W-1:0] den;
  logic                done;
  logic signed [W-1:0] quo;
  modport master (output start, output num, output den, input done, input quo);
  modport slave  (input start, input num, input den, output done, output quo);
endinterface : psr_div_if

// *** design/psr_divider.sv ***
// Signed restoring divider, one quotient bit per clock
`timescale 1ns/10ps
module psr_divider #(
  parameter int W = 32
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Request and answer
  psr_div_if.slave div
);
  localparam int CW = $clog2(W + 1);

  logic            busy;
  logic            neg;
  logic [CW-1:0]   cnt;
  logic [W-1:0]    quo_mag;
  logic [W:0]      rem;
  logic [W-1:0]    dvs;
  logic            done_r;
  logic [W-1:0]    quo_r;
  logic            next_busy;
  logic            next_neg;
  logic [CW-1:0]   next_cnt;
  logic [W-1:0]    next_quo_mag;
  logic [W:0]      next_rem;
  logic [W-1:0]    next_dvs;
  logic            next_done;
  logic [W-1:0]    next_quo;

  assign div.done = done_r;
  assign div.quo  = quo_r;

  // Shift-subtract step; a zero divisor answers zero at once
  always_comb
  begin
    logic [W:0] rem_sh;
    rem_sh       = {rem[W-1:0], quo_mag[W-1]};
    next_busy    = busy;
    next_neg     = neg;
    next_cnt     = cnt;
    next_quo_mag = quo_mag;
    next_rem     = rem;
    next_dvs     = dvs;
    next_done    = 1'b0;
    next_quo     = quo_r;
    if (!busy && div.start)
    begin
      if (div.den == '0)
      begin
        next_done = 1'b1;
        next_quo  = '0;
      end
      else
      begin
        next_busy    = 1'b1;
        next_neg     = div.num[W-1] ^ div.den[W-1];
        next_quo_mag = div.num[W-1] ? W'(-div.num) : W'(div.num);
        next_dvs     = div.den[W-1] ? W'(-div.den) : W'(div.den);
        next_rem     = '0;
        next_cnt     = CW'(W);
      end
    end
    else if (busy)
    begin
      if (rem_sh >= {1'b0, dvs})
      begin
        next_rem     = rem_sh - {1'b0, dvs};
        next_quo_mag = {quo_mag[W-2:0], 1'b1};
      end
      else
      begin
        next_rem     = rem_sh;
        next_quo_mag = {quo_mag[W-2:0], 1'b0};
      end
      next_cnt = cnt - CW'(1);
      if (cnt == CW'(1))
      begin
        next_busy = 1'b0;
        next_done = 1'b1;
        next_quo  = neg ? W'(-next_quo_mag) : next_quo_mag;
      end
    end
  end

  // State registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      busy    <= 1'b0;
      neg     <= 1'b0;
      cnt     <= '0;
      quo_mag <= '0;
      rem     <= '0;
      dvs     <= '0;
      done_r  <= 1'b0;
      quo_r   <= '0;
    end
    else
    begin
      busy    <= next_busy;
      neg     <= next_neg;
      cnt     <= next_cnt;
      quo_mag <= next_quo_mag;
      rem     <= next_rem;
      dvs     <= next_dvs;
      done_r  <= next_done;
      quo_r   <= next_quo;
    end
  end
endmodule : psr_divider

// *** test/psr_assertions.sv ***
// Port assertions of the PID speed regulator
`timescale 1ns/10ps
module psr_assertions (
  // Clock, reset and bus
  input wire logic               hclk,
  input wire logic               hresetn,
  input wire logic               hsel,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic               hready,
  input wire logic               hreadyout,
  input wire logic               hresp,
  input wire logic [31:0]        hrdata,
  // Command path
  input wire logic               run,
  input wire logic signed [15:0] ramped_speed_ref,
  input wire logic signed [15:0] pid_output,
  input wire logic signed [15:0] freq_command
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Regulator held off, or settled in its run
  sequence idle2_s; !run ##1 !run; endsequence
  sequence run4_s; run [*4]; endsequence
  hresp_okay_a: assert property (hresp == 1'b0) else $error("hresp not okay");
  ready_high_a: assert property (hresetn |=> hreadyout) else $error("hreadyout low");
  rdata_idle_a: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> hrdata == 32'h0000_0000)
    else $error("hrdata not zero");
  pid_idle_a: assert property (idle2_s |-> pid_output == 16'sh0000) else $error("pid_output not zero");
  cmd_follow_a: assert property (idle2_s |-> freq_command == $past(ramped_speed_ref)) else $error("not ramp");
  cmd_compose_a: assert property (run4_s ##0 $changed(pid_output)
    |-> freq_command == pid_output || freq_command == pid_output + ramped_speed_ref) else $error("bad command");
  pid_hold_a: assert property (run4_s ##0 $changed(pid_output)
    |=> (!run || $stable(pid_output)) [*8]) else $error("output moved between samples");
  cmd_steady_a: assert property (run4_s ##0 $stable(pid_output) |-> $stable(freq_command))
    else $error("command moved alone");
endmodule : psr_assertions
bind psr_regulator psr_assertions u_psr_assertions (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .hrdata, .run, .ramped_speed_ref, .pid_output, .freq_command);

// *** test/psr_plant.sv ***
// Sensors and ramp path feeding the regulator
`timescale 1ns/10ps
module psr_plant (
  // Levels set by the bench
  input  wire logic signed [11:0] v_set,
  input  wire logic [11:0]        c_set,
  input  wire logic signed [15:0] r_set,
  // Levels seen by the regulator
  output wire logic signed [11:0] volt_in,
  output wire logic [11:0]        current_in,
  output wire logic signed [15:0] ramped_speed_ref
);
  // Sensors track their level, ramp held steady
  assign volt_in = v_set;
  assign current_in = c_set;
  assign ramped_speed_ref = r_set;
endmodule : psr_plant

// *** test/psr_regulator_tb_top.sv ***
// Self-checking bench of the PID speed regulator
`timescale 1ns/10ps
module psr_regulator_tb_top;
  typedef struct {logic [31:0] vs, cs; logic [11:0] src; logic [15:0] db, gain;
    logic [11:0] vin, cin; logic [15:0] err, pid;} psr_case_type;
  localparam logic [31:0] DS = 32'h03E8_0000;
  // Bus, sensors and command path
  logic               hclk, hresetn, hsel, hwrite, run, hreadyout, hresp;
  logic [1:0]         htrans;
  logic [31:0]        haddr, hwdata, hrdata, rd;
  logic signed [11:0] v_set, volt_in;
  logic [11:0]        c_set, current_in;
  logic signed [15:0] r_set, ramped_speed_ref, pid_output, freq_command;
  int                 err_count, tests_run;
  logic [7:0]         ra [9] = '{8'h00, 8'h04, 8'h0C, 8'h4C, 8'h50, 8'h54, 8'h58, 8'h5C, 8'h6C};
  logic [31:0]        rv [9] = '{32'h0000_0000, DS, 32'h0000_0258, 32'h0000_0258, 32'h0000_0064,
                                 32'h0000_0014, 32'h0000_0000, 32'h0000_0000, 32'h0000_0258};
  psr_case_type       cases [5] = '{
    '{DS, DS, 12'h015, 16'h0000, 16'h0064, 12'h258, 12'h190, 16'h00C8, 16'h0078},
    '{32'h01F4_0000, 32'h0000_03E8, 12'h015, 16'h0000, 16'h0064, 12'h0FA, 12'h320, 16'h012C, 16'h00B4},
    '{DS, DS, 12'h015, 16'h0032, 16'h0064, 12'h28A, 12'h258, 16'h0000, 16'h0000},
    '{DS, DS, 12'h006, 16'h0000, 16'h0064, 12'hF9C, 12'h1F4, 16'h01F4, 16'h012C},
    '{DS, DS, 12'h015, 16'h0000, 16'h0000, 12'h258, 12'h190, 16'h00C8, 16'h0000}};
  psr_plant plant (.v_set, .c_set, .r_set, .volt_in, .current_in, .ramped_speed_ref);
  psr_regulator #(.SAMPLE_CYCLES(250)) uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .volt_in, .current_in, .run,
    .ramped_speed_ref, .pid_output, .freq_command);
  // One single word transfer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test();
    $display("mismatches %0d of %0d checks", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  // Clock of 8 ns
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge hclk);
    err_count++;
    stop_test();
  end
  // Reset values, exclusive cases, then trim mode
  initial
  begin
    {hresetn, hsel, hwrite, run, htrans, haddr, hwdata, v_set, c_set, r_set} = '0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    foreach (ra[i])
    begin
      bus(1'b0, ra[i], 32'h0000_0000);
      chk(rd, rv[i]);
    end
    bus(1'b1, 8'h54, 32'h0000_0000);
    bus(1'b1, 8'h00, 32'h0000_0001);
    run <= 1'b1;
    foreach (cases[i])
    begin
      bus(1'b1, 8'h04, cases[i].vs);
      bus(1'b1, 8'h08, cases[i].cs);
      bus(1'b1, 8'h40, 32'(cases[i].src));
      bus(1'b1, 8'h44, 32'(cases[i].db));
      bus(1'b1, 8'h50, 32'(cases[i].gain));
      v_set <= cases[i].vin;
      c_set <= cases[i].cin;
      repeat (600) @(posedge hclk);
      bus(1'b0, 8'h1C, 32'h0000_0000);
      chk(rd, 32'(cases[i].err));
      chk(32'(pid_output), 32'(cases[i].pid));
      chk(32'(freq_command), 32'(cases[i].pid));
    end
    run <= 1'b0;
    bus(1'b1, 8'h40, 32'h0000_0115);
    bus(1'b1, 8'h48, 32'h0000_0064);
    bus(1'b1, 8'h4C, 32'hFFE2_0032);
    bus(1'b1, 8'h50, 32'h0000_0064);
    r_set <= 16'sh00C8;
    repeat (4) @(posedge hclk);
    run <= 1'b1;
    repeat (3) @(posedge hclk);
    chk(32'(pid_output), 32'h0000_0064);
    chk(32'(freq_command), 32'h0000_012C);
    repeat (600) @(posedge hclk);
    chk(32'(pid_output), 32'h0000_0032);
    chk(32'(freq_command), 32'h0000_00FA);
    v_set <= 12'sh0C8;
    repeat (600) @(posedge hclk);
    chk(32'(pid_output), 32'hFFFF_FFE2);
    chk(32'(freq_command), 32'h0000_00AA);
    stop_test();
  end
endmodule : psr_regulator_tb_top
